// ===== flash_cmd_pkg.sv
package flash_cmd_pkg;

  // ------------------------------------------------------------
  // opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_VWREN = 8'h50;
  localparam logic [7:0] OP_WRSR1 = 8'h01;
  localparam logic [7:0] OP_WRSR2 = 8'h31;
  localparam logic [7:0] OP_WRSR3 = 8'h11;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_RDSR3 = 8'h15;
  localparam logic [7:0] OP_RDEAR = 8'hc8;
  localparam logic [7:0] OP_WREAR = 8'hc5;
  localparam logic [7:0] OP_EN4B = 8'hb7;
  localparam logic [7:0] OP_EX4B = 8'he9;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_READ4 = 8'h13;
  localparam logic [7:0] OP_FREAD = 8'h0b;

  // ------------------------------------------------------------
  // status fields and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] SR1_WMASK = 8'hfc;
  localparam logic [7:0] SR2_WMASK = 8'h7b;
  localparam logic [7:0] SR3_WMASK = 8'h66;
  localparam logic [7:0] NV_OTP = 8'h38;
  localparam logic [7:0] VOL_OTP = 8'h39;
  localparam logic [7:0] SR1_RST = 8'h00;
  localparam logic [7:0] SR2_RST = 8'h00;
  localparam logic [7:0] SR3_RST = 8'h60;
  localparam logic [7:0] EAR_RST = 8'h00;
  localparam int AMODE_DEF_BIT = 1;
  localparam logic [2:0] WSEL_SR1 = 3'h1;
  localparam logic [2:0] WSEL_SR12 = 3'h3;
  localparam logic [2:0] WSEL_SR2 = 3'h2;
  localparam logic [2:0] WSEL_SR3 = 3'h4;

  // ------------------------------------------------------------
  // timing and bit counts
  // ------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int TW_NS = 1000000;
  localparam int TW_CYC = (TW_NS + CLK_NS - 1) / CLK_NS;
  localparam int TSHSL2_NS = 50;
  localparam int VOL_CYC = (TSHSL2_NS / CLK_NS < 1) ? 1 : TSHSL2_NS / CLK_NS;
  localparam logic [5:0] OP_LAST = 6'h07;
  localparam logic [5:0] A24_LAST = 6'h17;
  localparam logic [5:0] A32_LAST = 6'h1f;
  localparam logic [5:0] DUMMY_LAST = 6'h07;
  localparam logic [5:0] ONE_BYTE = 6'h08;
  localparam logic [5:0] TWO_BYTES = 6'h10;
  localparam logic [5:0] CNT_MAX = 6'h3f;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OP = 3'b001,
    ST_ADDR = 3'b010,
    ST_DUMMY = 3'b011,
    ST_DIN = 3'b100,
    ST_OUT = 3'b101,
    ST_SKIP = 3'b110
  } frame_st_t;

  typedef enum logic [2:0] {
    SEL_MEM = 3'b000,
    SEL_SR1 = 3'b001,
    SEL_SR2 = 3'b010,
    SEL_SR3 = 3'b011,
    SEL_EAR = 3'b100
  } out_sel_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic din;
  } spi_pins_t;

  typedef struct packed {
    logic [7:0] sr1;
    logic [7:0] sr2;
    logic [7:0] sr3;
  } status_t;

  localparam status_t STATUS_RST = {SR1_RST, SR2_RST, SR3_RST};

endpackage

// ===== pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  if (W < 1) begin : g_chk
    $error("pin_sync needs at least one bit");
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= RST;
      q_r <= RST;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule

// ===== cycle_timer.sv
`timescale 1ns/100ps
module cycle_timer #(
  parameter int W = 24
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [W-1:0] load,
  output logic done
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic run_r;
  logic run_nxt;
  logic done_r;
  logic done_nxt;

  if (W < 2) begin : g_chk
    $error("cycle_timer width too small");
  end

  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    done_nxt = 1'b0;
    if (start) begin
      cnt_nxt = load;
      run_nxt = 1'b1;
    end else if (run_r) begin
      if (cnt_r <= W'(1)) begin
        cnt_nxt = '0;
        run_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;
endmodule

// ===== flash_cmd_core.sv
// Contract
// - status writes touch only writable fields
// - lock bits one-time; volatile write never clears
// - non-volatile status write needs write enable
// - 50h then status write updates volatile copy
// - reset restores non-volatile status
// - non-volatile write runs timed busy cycle
// - write enable clears when cycle ends
// - volatile write applies quickly, busy stays 0
// - 01h with sixteen bits writes registers 1,2
// - C8h shifts extended address out, MSB first
// - 3-byte mode uses extended byte as top
// - C5h loads extended address when write-enabled
// - extended address clears on any reset
// - 4-byte mode addresses overwrite extended byte
// - lone B7h enters 4-byte address mode
// - lone E9h returns to 3-byte mode
// - 03h streams bytes MSB first, auto-increment
// - reads ignored while a cycle is busy
// - reads accepted only in single-line mode
// - 13h always takes a 32-bit address
// - 0Bh inserts eight dummy clocks before data
// - lone 06h sets write enable latch
// - status reads accepted at any time
`timescale 1ns/100ps
module flash_cmd_core
  import flash_cmd_pkg::*;
#(
  parameter int TW_CYCLES = TW_CYC,
  parameter int TW_W = 24
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic soft_rst,
  input wire logic quad_mode,
  output logic [31:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_data,
  output logic busy,
  output logic wen,
  output logic addr_4byte,
  output status_t status,
  output logic [7:0] ext_addr
);
  localparam int VOL_LAT = VOL_CYC;

  if (TW_CYCLES < 1 || TW_CYCLES >= (1 << TW_W)) begin : g_tw_chk
    $error("tw count does not fit the timer");
  end

  // ------------------------------------------------------------
  // pin sampling
  // ------------------------------------------------------------
  spi_pins_t pins_s;
  logic sck_q_r;
  logic cs_q_r;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;

  pin_sync #(.W(3), .RST(3'h4)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({cs_n, sck, serial_in}),
    .q(pins_s)
  );

  assign sck_rise = pins_s.sck & ~sck_q_r;
  assign sck_fall = ~pins_s.sck & sck_q_r;
  assign cs_rise = pins_s.cs_n & ~cs_q_r;
  assign cs_fall = ~pins_s.cs_n & cs_q_r;

  function automatic logic is_rdsr(input logic [7:0] o);
    return o == OP_RDSR1 || o == OP_RDSR2 || o == OP_RDSR3;
  endfunction

  function automatic status_t apply(input status_t old, input status_t d,
                                    input logic [2:0] wsel, input logic [7:0] otp);
    status_t r;
    r = old;
    if (wsel[0]) r.sr1 = (old.sr1 & ~SR1_WMASK) | (d.sr1 & SR1_WMASK);
    if (wsel[1]) r.sr2 = (old.sr2 & ~SR2_WMASK) | (d.sr2 & SR2_WMASK) | (old.sr2 & otp);
    if (wsel[2]) r.sr3 = (old.sr3 & ~SR3_WMASK) | (d.sr3 & SR3_WMASK);
    return r;
  endfunction

  // ------------------------------------------------------------
  // frame engine
  // ------------------------------------------------------------
  frame_st_t st_r, st_nxt;
  out_sel_t sel_r, sel_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [31:0] sh_r, sh_nxt;
  logic [7:0] op_r, op_nxt;
  logic a32_r, a32_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [7:0] byte_r, byte_nxt;
  logic fetch_r, fetch_nxt;
  logic cap_r;
  logic dout_r, dout_nxt;
  logic oe_r, oe_nxt;
  logic [7:0] opc;
  logic [31:0] full_addr;
  logic ear_hit;
  logic [7:0] sr1_rd;
  logic [7:0] sr3_rd;
  logic [7:0] ear_r;
  logic busy_r;
  logic wen_r;
  logic amode_r;
  status_t vol_r;

  assign sr1_rd = {vol_r.sr1[7:2], wen_r, busy_r};
  assign sr3_rd = {vol_r.sr3[7:1], amode_r};
  assign opc = {sh_r[6:0], pins_s.din};

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    op_nxt = op_r;
    a32_nxt = a32_r;
    addr_nxt = addr_r;
    byte_nxt = byte_r;
    sel_nxt = sel_r;
    fetch_nxt = 1'b0;
    dout_nxt = dout_r;
    oe_nxt = oe_r;
    ear_hit = 1'b0;
    full_addr = '0;
    if (cap_r) begin
      case (sel_r)
        SEL_MEM: byte_nxt = mem_data;
        SEL_SR1: byte_nxt = sr1_rd;
        SEL_SR2: byte_nxt = vol_r.sr2;
        SEL_SR3: byte_nxt = sr3_rd;
        default: byte_nxt = ear_r;
      endcase
    end
    if (cs_rise || pins_s.cs_n) begin
      st_nxt = ST_IDLE;
      oe_nxt = 1'b0;
      dout_nxt = 1'b0;
    end else if (cs_fall) begin
      st_nxt = ST_OP;
      cnt_nxt = '0;
    end else if (sck_rise && st_r != ST_OUT) begin
      sh_nxt = {sh_r[30:0], pins_s.din};
      cnt_nxt = (cnt_r == CNT_MAX) ? cnt_r : cnt_r + 6'h01;
      case (st_r)
        ST_OP: begin
          if (cnt_r == OP_LAST) begin
            op_nxt = opc;
            cnt_nxt = '0;
            a32_nxt = (opc == OP_READ4) || amode_r;
            if (busy_r && !is_rdsr(opc)) begin
              st_nxt = ST_SKIP;
            end else begin
              case (opc)
                OP_RDSR1: begin
                  st_nxt = ST_OUT;
                  sel_nxt = SEL_SR1;
                  fetch_nxt = 1'b1;
                end
                OP_RDSR2: begin
                  st_nxt = ST_OUT;
                  sel_nxt = SEL_SR2;
                  fetch_nxt = 1'b1;
                end
                OP_RDSR3: begin
                  st_nxt = ST_OUT;
                  sel_nxt = SEL_SR3;
                  fetch_nxt = 1'b1;
                end
                OP_RDEAR: begin
                  st_nxt = ST_OUT;
                  sel_nxt = SEL_EAR;
                  fetch_nxt = 1'b1;
                end
                OP_READ, OP_READ4, OP_FREAD: begin
                  st_nxt = quad_mode ? ST_SKIP : ST_ADDR;
                end
                default: st_nxt = ST_DIN;
              endcase
            end
          end
        end
        ST_ADDR: begin
          if (cnt_r == (a32_r ? A32_LAST : A24_LAST)) begin
            // upper byte comes from the extended register in 3-byte mode
            full_addr = a32_r ? {sh_r[30:0], pins_s.din} :
                                {ear_r, sh_r[22:0], pins_s.din};
            ear_hit = amode_r;
            addr_nxt = full_addr;
            sel_nxt = SEL_MEM;
            fetch_nxt = 1'b1;
            cnt_nxt = '0;
            st_nxt = (op_r == OP_FREAD) ? ST_DUMMY : ST_OUT;
          end
        end
        ST_DUMMY: begin
          if (cnt_r == DUMMY_LAST) begin
            st_nxt = ST_OUT;
            cnt_nxt = '0;
          end
        end
        default: ;
      endcase
    end else if (sck_fall && st_r == ST_OUT) begin
      dout_nxt = byte_r[3'h7 - cnt_r[2:0]];
      oe_nxt = 1'b1;
      cnt_nxt = cnt_r + 6'h01;
      if (cnt_r[2:0] == 3'h7) begin
        // next byte is fetched while bit 0 is on the wire; status repeats live
        fetch_nxt = 1'b1;
        if (sel_r == SEL_MEM) begin
          addr_nxt = addr_r + 32'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_IDLE;
      cnt_r <= '0;
      sh_r <= '0;
      op_r <= '0;
      a32_r <= 1'b0;
      addr_r <= '0;
      byte_r <= '0;
      sel_r <= SEL_MEM;
      fetch_r <= 1'b0;
      cap_r <= 1'b0;
      dout_r <= 1'b0;
      oe_r <= 1'b0;
      sck_q_r <= 1'b0;
      cs_q_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      op_r <= op_nxt;
      a32_r <= a32_nxt;
      addr_r <= addr_nxt;
      byte_r <= byte_nxt;
      sel_r <= sel_nxt;
      fetch_r <= fetch_nxt;
      cap_r <= fetch_r;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      sck_q_r <= pins_s.sck;
      cs_q_r <= pins_s.cs_n;
    end
  end

  // ------------------------------------------------------------
  // status, mode and extended address
  // ------------------------------------------------------------
  status_t nv_r, nv_nxt, vol_nxt, pend_r, pend_nxt, new_sr, vol_wr_val;
  logic [2:0] psel_r, psel_nxt, wsel;
  logic wen_nxt, busy_nxt, amode_nxt, vwen_r, vwen_nxt;
  logic [7:0] ear_nxt;
  logic tw_start;
  logic tw_done;
  logic lone;

  cycle_timer #(.W(TW_W)) u_tw (
    .clk(clk),
    .nrst(nrst),
    .start(tw_start),
    .load(TW_W'(TW_CYCLES)),
    .done(tw_done)
  );

  assign lone = cnt_r == 6'h00;
  assign vol_wr_val = apply(vol_r, new_sr, wsel, VOL_OTP);

  always_comb begin
    new_sr.sr1 = (cnt_r == TWO_BYTES) ? sh_r[15:8] : sh_r[7:0];
    new_sr.sr2 = sh_r[7:0];
    new_sr.sr3 = sh_r[7:0];
    wsel = 3'h0;
    case (op_r)
      OP_WRSR1: begin
        if (cnt_r == ONE_BYTE) wsel = WSEL_SR1;
        else if (cnt_r == TWO_BYTES) wsel = WSEL_SR12;
      end
      OP_WRSR2: if (cnt_r == ONE_BYTE) wsel = WSEL_SR2;
      OP_WRSR3: if (cnt_r == ONE_BYTE) wsel = WSEL_SR3;
      default: wsel = 3'h0;
    endcase
  end

  always_comb begin
    nv_nxt = nv_r;
    vol_nxt = vol_r;
    pend_nxt = pend_r;
    psel_nxt = psel_r;
    wen_nxt = wen_r;
    busy_nxt = busy_r;
    amode_nxt = amode_r;
    vwen_nxt = vwen_r;
    ear_nxt = ear_r;
    tw_start = 1'b0;
    if (tw_done) begin
      nv_nxt = apply(nv_r, pend_r, psel_r, NV_OTP);
      vol_nxt = apply(vol_r, pend_r, psel_r, VOL_OTP);
      busy_nxt = 1'b0;
      wen_nxt = 1'b0;
    end
    if (ear_hit) ear_nxt = full_addr[31:24];
    if (cs_rise && st_r == ST_DIN) begin
      vwen_nxt = 1'b0;
      case (op_r)
        OP_WREN: if (lone) wen_nxt = 1'b1;
        OP_WRDI: if (lone) wen_nxt = 1'b0;
        OP_VWREN: if (lone) vwen_nxt = 1'b1;
        OP_EN4B: if (lone) amode_nxt = 1'b1;
        OP_EX4B: if (lone) amode_nxt = 1'b0;
        OP_WREAR: if (wen_r && cnt_r == ONE_BYTE) ear_nxt = sh_r[7:0];
        default: begin
          if (wsel != 3'h0) begin
            if (wen_r) begin
              pend_nxt = new_sr;
              psel_nxt = wsel;
              busy_nxt = 1'b1;
              tw_start = 1'b1;
            end else if (vwen_r) begin
              vol_nxt = vol_wr_val;
            end
          end
        end
      endcase
    end
    if (soft_rst) begin
      vol_nxt = nv_r;
      ear_nxt = EAR_RST;
      wen_nxt = 1'b0;
      vwen_nxt = 1'b0;
      amode_nxt = nv_r.sr3[AMODE_DEF_BIT];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nv_r <= STATUS_RST;
      vol_r <= STATUS_RST;
      pend_r <= STATUS_RST;
      psel_r <= 3'h0;
      wen_r <= 1'b0;
      busy_r <= 1'b0;
      amode_r <= SR3_RST[AMODE_DEF_BIT];
      vwen_r <= 1'b0;
      ear_r <= EAR_RST;
    end else begin
      nv_r <= nv_nxt;
      vol_r <= vol_nxt;
      pend_r <= pend_nxt;
      psel_r <= psel_nxt;
      wen_r <= wen_nxt;
      busy_r <= busy_nxt;
      amode_r <= amode_nxt;
      vwen_r <= vwen_nxt;
      ear_r <= ear_nxt;
    end
  end

  assign serial_out = dout_r;
  assign serial_out_oe = oe_r;
  assign mem_addr = addr_r;
  assign mem_rd = fetch_r;
  assign busy = busy_r;
  assign wen = wen_r;
  assign addr_4byte = amode_r;
  assign status = vol_r;
  assign ext_addr = ear_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_lone(logic [7:0] o);
    cs_rise && st_r == ST_DIN && op_r == o && lone && !soft_rst;
  endsequence

  sequence s_vol_wr;
    cs_rise && st_r == ST_DIN && wsel != 3'h0 && !wen_r && vwen_r && !soft_rst && !tw_done;
  endsequence

  wen_set_a: assert property (s_lone(OP_WREN) |=> wen_r)
    else $error("write enable not latched");
  mode_enter_a: assert property (s_lone(OP_EN4B) |=> amode_r)
    else $error("4-byte mode not entered");
  mode_exit_a: assert property (s_lone(OP_EX4B) |=> !amode_r)
    else $error("4-byte mode not left");
  nv_gate_a: assert property ($rose(busy_r) |-> $past(wen_r))
    else $error("write cycle without write enable");
  nv_busy_a: assert property (tw_start |=> busy_r [*2])
    else $error("busy not held during write cycle");
  nv_end_a: assert property (tw_done |=> !busy_r && !wen_r)
    else $error("write cycle end did not clear flags");
  vol_apply_a: assert property (s_vol_wr |-> ##[1:VOL_LAT] vol_r == $past(vol_wr_val) && !busy_r)
    else $error("volatile write not applied");
  otp_keep_a: assert property (##1 ((($past(nv_r.sr2) & ~nv_r.sr2) & NV_OTP) == 8'h00))
    else $error("lock bit cleared");
  ro_bits_a: assert property (##1 ((nv_r.sr1 ^ $past(nv_r.sr1)) & ~SR1_WMASK) == 8'h00 &&
                              ((nv_r.sr3 ^ $past(nv_r.sr3)) & ~SR3_WMASK) == 8'h00)
    else $error("read-only status bit changed");
  ear_clr_a: assert property (soft_rst |=> ear_r == EAR_RST)
    else $error("extended address not cleared");
  ear_4b_a: assert property (ear_hit && !soft_rst |=> ear_r == $past(full_addr[31:24]))
    else $error("extended address not replaced");
  addr_3b_a: assert property ((st_r == ST_ADDR && !a32_r) ##1 (st_r == ST_OUT || st_r == ST_DUMMY)
                              |-> mem_rd && mem_addr[31:24] == ear_r)
    else $error("upper address byte wrong");
  rd_busy_a: assert property (st_r == ST_OP && sck_rise && cnt_r == OP_LAST && busy_r &&
                              !pins_s.cs_n && !cs_fall && !is_rdsr(opc) |=> st_r == ST_SKIP)
    else $error("command accepted while busy");
  msb_first_a: assert property (sck_fall && st_r == ST_OUT && cnt_r[2:0] == 3'h0 &&
                                !pins_s.cs_n |=> serial_out == $past(byte_r[7]) && serial_out_oe)
    else $error("first output bit not msb");
endmodule

// ===== spi_host_model.sv
`timescale 1ns/100ps
module spi_host_model
  import flash_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic miso,
  output spi_pins_t pins
);
  logic [31:0] result;
  event done_ev;

  initial begin
    pins = '{cs_n: 1'b1, sck: 1'b0, din: 1'b0};
    result = '0;
  end

  // mode 0, 8 clk per bit: 5 low then 3 high; serial_out is taken just before
  // each rise so the device's sync delay after the fall has long settled
  task automatic frame(input logic [63:0] tx, input int nb, input int nrx);
    logic [63:0] rx;
    rx = '0;
    @(posedge clk) pins.cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = nb - 1; i >= 0; i--) begin
      pins.din <= tx[i];
      repeat (5) @(posedge clk);
      rx = {rx[62:0], miso};
      pins.sck <= 1'b1;
      repeat (3) @(posedge clk);
      pins.sck <= 1'b0;
    end
    repeat (5) @(posedge clk);
    pins.cs_n <= 1'b1;
    repeat (6) @(posedge clk);
    // released data line must not keep its last level
    pins.din <= ~pins.din;
    if (nrx > 0) begin
      result = 32'(rx & ((64'h1 << nrx) - 64'h1));
      -> done_ev;
    end
  endtask
endmodule

// ===== serial_flash_status_addr_read_cmds_test.sv
`timescale 1ns/100ps
module serial_flash_status_addr_read_cmds_test;
  import flash_cmd_pkg::*;
  logic clk, nrst, soft_rst, quad_mode, serial_out, oe, busy, wen, addr_4byte, mem_rd;
  logic miso;
  logic [31:0] mem_addr;
  logic [7:0] mem_data, ext_addr, e;
  status_t status;
  spi_pins_t pins;
  logic [31:0] exp_q[$];
  logic [31:0] rnd, a;
  int n_errors, tests_run, n_rd, cycles, rd0;

  flash_cmd_core #(.TW_CYCLES(1000)) DUT (.clk(clk), .nrst(nrst), .cs_n(pins.cs_n),
    .sck(pins.sck), .serial_in(pins.din), .serial_out(serial_out), .serial_out_oe(oe),
    .soft_rst(soft_rst), .quad_mode(quad_mode), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_data(mem_data), .busy(busy), .wen(wen), .addr_4byte(addr_4byte),
    .status(status), .ext_addr(ext_addr));
  spi_host_model host (.clk(clk), .miso(miso), .pins(pins));

  // an undriven data line floats high through its pull-up, so a missing enable shows up
  assign miso = oe ? serial_out : 1'b1;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // array model: one-cycle latency, content depends on every address byte
  function automatic logic [7:0] md(input logic [31:0] ad);
    return ad[7:0] ^ ad[15:8] ^ {ad[19:16], ad[23:20]} ^ ad[31:24];
  endfunction

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  always @(posedge clk) begin
    if (mem_rd) begin
      mem_data <= md(mem_addr);
      n_rd <= n_rd + 1;
    end
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic compare(input logic [31:0] got, input logic [31:0] ex);
    tests_run++;
    if (got !== ex) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, ex);
    end
  endtask

  // oldest note against each read-back that the host collects
  initial begin
    forever begin
      @(host.done_ev);
      if (exp_q.size() == 0) compare(host.result, 32'hdead_beef);
      else compare(host.result, exp_q.pop_front());
    end
  end

  task automatic xfer(input logic [63:0] tx, input int nb, input int nrx, input logic [31:0] ex);
    if (nrx > 0) exp_q.push_back(ex);
    host.frame(tx, nb, nrx);
  endtask

  task automatic op(input logic [7:0] code);
    xfer({56'h0, code}, 8, 0, '0);
  endtask

  task automatic wait_idle;
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask

  task automatic pulse_reset;
    @(posedge clk) soft_rst <= 1'b1;
    @(posedge clk) soft_rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic conclude;
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    soft_rst = 1'b0;
    quad_mode = 1'b0;
    mem_data = 8'h00;
    n_errors = 0;
    tests_run = 0;
    n_rd = 0;
    cycles = 0;
    rnd = 32'h8498f263;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    compare(32'(status), 32'(STATUS_RST));
    compare({24'h0, ext_addr}, 32'h0);
    op(OP_VWREN);
    xfer({48'h0, OP_WRSR3, 8'hff}, 16, 0, '0);
    repeat (3) @(posedge clk);
    compare({30'h0, busy, wen}, 32'h0);
    compare({24'h0, status.sr3}, 32'h66);
    pulse_reset();
    compare(32'(status), 32'(STATUS_RST));
    xfer({48'h0, OP_WREAR, 8'h5c}, 16, 0, '0);
    compare({24'h0, ext_addr}, 32'h0);
    op(OP_WREN);
    op(OP_WRDI);
    xfer({48'h0, OP_WRSR3, 8'hff}, 16, 0, '0);
    repeat (3) @(posedge clk);
    compare({16'h0, status.sr3, 6'h0, busy, wen}, 32'h6000);
    op(OP_WREN);
    compare({31'h0, wen}, 32'h1);
    xfer({40'h0, OP_WRSR1, 16'ha55a}, 24, 0, '0);
    compare({31'h0, busy}, 32'h1);
    xfer({48'h0, OP_RDSR1, 8'h0}, 16, 8, 32'h03);
    rd0 = n_rd;
    xfer({16'h0, OP_READ, 24'h0, 16'h0}, 48, 0, '0);
    compare(32'(n_rd - rd0), 32'h0);
    wait_idle();
    compare({16'h0, status.sr1, status.sr2}, 32'ha45a);
    compare({31'h0, wen}, 32'h0);
    op(OP_WREN);
    xfer({48'h0, OP_WRSR1, 8'h00}, 16, 0, '0);
    wait_idle();
    compare({16'h0, status.sr1, status.sr2}, 32'h005a);
    op(OP_VWREN);
    xfer({48'h0, OP_WRSR2, 8'h00}, 16, 0, '0);
    repeat (3) @(posedge clk);
    compare({24'h0, status.sr2}, 32'h18);
    rnd = lfsr(rnd);
    e = rnd[7:0];
    op(OP_WREN);
    xfer({48'h0, OP_WREAR, e}, 16, 0, '0);
    compare({24'h0, ext_addr}, {24'h0, e});
    xfer({48'h0, OP_RDEAR, 8'h0}, 16, 8, {24'h0, e});
    rnd = lfsr(rnd);
    a = {e, rnd[23:0]};
    xfer({16'h0, OP_READ, a[23:0], 16'h0}, 48, 16, {16'h0, md(a), md(a + 1)});
    rnd = lfsr(rnd);
    a = {e, rnd[23:0]};
    xfer({16'h0, OP_FREAD, a[23:0], 16'h0}, 48, 8, {24'h0, md(a)});
    quad_mode <= 1'b1;
    rd0 = n_rd;
    xfer({16'h0, OP_READ, a[23:0], 16'h0}, 48, 0, '0);
    compare(32'(n_rd - rd0), 32'h0);
    quad_mode <= 1'b0;
    rnd = lfsr(rnd);
    a = rnd;
    xfer({16'h0, OP_READ4, a, 8'h0}, 48, 8, {24'h0, md(a)});
    op(OP_EN4B);
    compare({31'h0, addr_4byte}, 32'h1);
    rnd = lfsr(rnd);
    a = rnd;
    xfer({16'h0, OP_READ, a, 8'h0}, 48, 8, {24'h0, md(a)});
    compare({24'h0, ext_addr}, {24'h0, a[31:24]});
    op(OP_EX4B);
    compare({31'h0, addr_4byte}, 32'h0);
    xfer({48'h0, OP_RDEAR, 8'h0}, 16, 8, {24'h0, a[31:24]});
    pulse_reset();
    compare({24'h0, ext_addr}, 32'h0);
    repeat (4) @(posedge clk);
    compare(32'(exp_q.size()), 32'h0);
    conclude();
  end
endmodule
